// ### src/tus_pkg.sv
package tus_pkg;

  // Setpoint indexes of the system group
  localparam logic [7:0] IDX_MAINT     = 8'h08;
  localparam logic [7:0] IDX_TRIP      = 8'h09;
  localparam logic [7:0] IDX_DIRECTION = 8'h0b;
  localparam logic [7:0] IDX_SIGN      = 8'h0c;
  localparam logic [7:0] IDX_WINDOW    = 8'h0d;
  localparam logic [7:0] IDX_INTERVAL  = 8'h0e;
  localparam logic [7:0] IDX_RELAY_ONE = 8'h11;
  localparam logic [7:0] IDX_RELAY_TWO = 8'h12;
  localparam logic [7:0] IDX_PHASE     = 8'h14;
  localparam logic [7:0] IDX_LIFE      = 8'h17;

  // Field positions in the maintenance word
  localparam int MAINT_STATE_BIT  = 8;
  localparam int MAINT_REMOTE_BIT = 0;

  // Values after reset
  localparam logic [2:0]  RST_TRIP     = 3'h1;
  localparam logic [5:0]  RST_INTERVAL = 6'h0f;
  localparam logic [6:0]  RST_LIFE     = 7'h4b;
  localparam logic [15:0] RST_RELAY    = 16'h0000;

  // Accepted write ranges
  localparam logic [15:0] TRIP_MIN     = 16'h0001;
  localparam logic [15:0] TRIP_MAX     = 16'h0005;
  localparam logic [15:0] TRIP_MAX_CAP = 16'h0004;
  localparam logic [15:0] SIGN_MAX     = 16'h0002;
  localparam logic [15:0] ONE_BIT_MAX  = 16'h0001;
  localparam logic [15:0] INTERVAL_MIN = 16'h0005;
  localparam logic [15:0] INTERVAL_MAX = 16'h003c;
  localparam logic [15:0] LIFE_MIN     = 16'h0032;
  localparam logic [15:0] LIFE_MAX     = 16'h0064;
  localparam logic [6:0]  LIFE_FULL    = 7'h64;

  // Capped frame and its ratings in amperes
  localparam logic [2:0]  FRAME_CAPPED = 3'h4;
  localparam logic [12:0] RATING_A     = 13'h0258;
  localparam logic [12:0] RATING_B     = 13'h0276;

  // Trip multiples in tenths of rated current
  localparam logic [6:0] MULT_1 = 7'h19;
  localparam logic [6:0] MULT_2 = 7'h28;
  localparam logic [6:0] MULT_3 = 7'h3c;
  localparam logic [6:0] MULT_4 = 7'h50;
  localparam logic [6:0] MULT_5 = 7'h64;

  typedef enum logic [1:0] {
    TUS_SIGN_IEC,
    TUS_SIGN_IEEE,
    TUS_SIGN_IEEE_OLD
  } tus_sign_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  index;
    logic [15:0] wdata;
  } tus_req_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } tus_rsp_s;

  typedef struct packed {
    logic      [6:0] trip_tenths;
    logic            supply_reverse;
    tus_sign_e       sign_conv;
    logic            demand_sliding;
    logic      [5:0] demand_minutes;
    logic            phase_clockwise;
    logic      [6:0] life_threshold;
  } tus_cfg_s;

endpackage

// ### src/tus_setpoints.sv
// Operation
// - Bit 8 of the maintenance word shows maintenance active; upper byte ignores writes.
// - Maintenance status combines rotary switch, terminal input and remote request.
// - Bit 0 of the maintenance word is a stored remote request, read back.
// - Trip level codes 1..5 decode to 2.5, 4, 6, 8, 10 times rated current.
// - Capped frame at 600 A or 630 A limits trip level to 8 times.
// - One-bit supply direction, forward or reverse, only on the metering variant.
// - Sign convention 0 IEC, 1 IEEE, 2 older IEEE.
// - Demand window 0 fixed, 1 sliding.
// - Demand interval 5 to 60 minutes, applied to demand calculation.
// - Phase sequence 0 counterclockwise, 1 clockwise.
// - Residual-life alarm level accepts 50 to 100, default 75.
// - Alarm threshold is 100 minus the level, as remaining-life percent.
`timescale 1ns/100ps
module tus_setpoints
  import tus_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire tus_req_s    req,
  input  wire logic        maint_switch,
  input  wire logic        maint_terminal,
  input  wire logic        volt_variant,
  input  wire logic [2:0]  frame_size,
  input  wire logic [12:0] rated_amps,
  input  wire logic [6:0]  life_remaining,
  output tus_rsp_s         rsp,
  output tus_cfg_s         cfg,
  output logic             maint_active,
  output logic             life_alarm,
  output logic [15:0]      relay_one,
  output logic [15:0]      relay_two
);

  //////////////////////////////////////////////////////////////////////////////
  // Stored setpoints and pin synchronisers

  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic        maint_remote;
  logic [2:0]  trip_code;
  logic        direction;
  logic [1:0]  sign_code;
  logic        window;
  logic [5:0]  interval;
  logic        phase;
  logic [6:0]  life_level;

  logic        capped;
  logic        known;
  logic        variant_only;
  logic        value_ok;
  logic        error;
  logic        accept;
  logic [15:0] next_rdata;
  logic [15:0] trip_top;
  logic [6:0]  next_trip;

  // Pins are asynchronous to clk, two stages before any use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {maint_terminal, maint_switch};
      pin_sync <= pin_meta;
    end
  end

  // Rated 600 A or 630 A on the capped frame
  assign capped   = (frame_size == FRAME_CAPPED) &&
                    ((rated_amps == RATING_A) || (rated_amps == RATING_B));
  assign trip_top = capped ? TRIP_MAX_CAP : TRIP_MAX;

  //////////////////////////////////////////////////////////////////////////////
  // Index decode, range check and read mux

  always_comb begin
    known        = 1'b1;
    variant_only = 1'b1;
    value_ok     = 1'b1;
    next_rdata   = 16'h0000;
    unique case (req.index)
      IDX_MAINT: begin
        variant_only = 1'b0;
        next_rdata[MAINT_STATE_BIT]  = maint_active;
        next_rdata[MAINT_REMOTE_BIT] = maint_remote;
      end
      IDX_TRIP: begin
        next_rdata = {13'h0, trip_code};
        value_ok   = (req.wdata >= TRIP_MIN) && (req.wdata <= trip_top);
      end
      IDX_DIRECTION: begin
        next_rdata = {15'h0, direction};
        value_ok   = req.wdata <= ONE_BIT_MAX;
      end
      IDX_SIGN: begin
        next_rdata = {14'h0, sign_code};
        value_ok   = req.wdata <= SIGN_MAX;
      end
      IDX_WINDOW: begin
        next_rdata = {15'h0, window};
        value_ok   = req.wdata <= ONE_BIT_MAX;
      end
      IDX_INTERVAL: begin
        next_rdata = {10'h0, interval};
        value_ok   = (req.wdata >= INTERVAL_MIN) && (req.wdata <= INTERVAL_MAX);
      end
      IDX_RELAY_ONE: begin
        variant_only = 1'b0;
        next_rdata   = relay_one;
      end
      IDX_RELAY_TWO: begin
        variant_only = 1'b0;
        next_rdata   = relay_two;
      end
      IDX_PHASE: begin
        next_rdata = {15'h0, phase};
        value_ok   = req.wdata <= ONE_BIT_MAX;
      end
      IDX_LIFE: begin
        next_rdata = {9'h0, life_level};
        value_ok   = (req.wdata >= LIFE_MIN) && (req.wdata <= LIFE_MAX);
      end
      default: begin
        known        = 1'b0;
        variant_only = 1'b0;
      end
    endcase
  end

  // A refused access leaves every stored value alone
  assign error  = !known || (variant_only && !volt_variant) || (req.write && !value_ok);
  assign accept = req.valid && req.write && !error;

  //////////////////////////////////////////////////////////////////////////////
  // Setpoint storage

  // Upper byte of the maintenance word has no storage, so writes there vanish
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      maint_remote <= 1'b0;
      trip_code    <= RST_TRIP;
      direction    <= 1'b0;
      sign_code    <= 2'h0;
      window       <= 1'b0;
      interval     <= RST_INTERVAL;
      relay_one    <= RST_RELAY;
      relay_two    <= RST_RELAY;
      phase        <= 1'b0;
      life_level   <= RST_LIFE;
    end else if (accept) begin
      unique case (req.index)
        IDX_MAINT:     maint_remote <= req.wdata[MAINT_REMOTE_BIT];
        IDX_TRIP:      trip_code    <= req.wdata[2:0];
        IDX_DIRECTION: direction    <= req.wdata[0];
        IDX_SIGN:      sign_code    <= req.wdata[1:0];
        IDX_WINDOW:    window       <= req.wdata[0];
        IDX_INTERVAL:  interval     <= req.wdata[5:0];
        IDX_RELAY_ONE: relay_one    <= req.wdata;
        IDX_RELAY_TWO: relay_two    <= req.wdata;
        IDX_PHASE:     phase        <= req.wdata[0];
        IDX_LIFE:      life_level   <= req.wdata[6:0];
        default:       life_level   <= life_level;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer to the controller, one cycle after the request

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.error <= req.valid && error;
      rsp.rdata <= (req.valid && !error) ? next_rdata : 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Maintenance status

  // Any of the three sources turns maintenance on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      maint_active <= 1'b0;
    end else begin
      maint_active <= pin_sync[0] | pin_sync[1] | maint_remote;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded settings for protection and metering

  // A stored 10x code is still clamped if the frame becomes capped later
  always_comb begin
    unique case (trip_code)
      3'h2:    next_trip = MULT_2;
      3'h3:    next_trip = MULT_3;
      3'h4:    next_trip = MULT_4;
      3'h5:    next_trip = capped ? MULT_4 : MULT_5;
      default: next_trip = MULT_1;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= '{trip_tenths: MULT_1, sign_conv: TUS_SIGN_IEC, demand_minutes: RST_INTERVAL,
               life_threshold: LIFE_FULL - RST_LIFE, default: '0};
    end else begin
      cfg.trip_tenths     <= next_trip;
      cfg.supply_reverse  <= direction & volt_variant;
      cfg.sign_conv       <= tus_sign_e'(sign_code);
      cfg.demand_sliding  <= window;
      cfg.demand_minutes  <= interval;
      cfg.phase_clockwise <= phase;
      cfg.life_threshold  <= LIFE_FULL - life_level;
    end
  end

  // Alarm when remaining life falls to the threshold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      life_alarm <= 1'b0;
    end else begin
      life_alarm <= life_remaining <= cfg.life_threshold;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_state_readback: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && !req.write && req.index == IDX_MAINT
      |=> rsp.rdata[MAINT_STATE_BIT] == $past(maint_active) && rsp.rdata[15:9] == 7'h00)
    else $error("maintenance state read back wrong");

  a_status_combine: assert property (@(posedge clk) disable iff (!rstn)
    ##1 maint_active == ($past(pin_sync[0]) | $past(pin_sync[1]) | $past(maint_remote)))
    else $error("maintenance status not combined");

  a_remote_store: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && req.write && req.index == IDX_MAINT
      |=> maint_remote == $past(req.wdata[MAINT_REMOTE_BIT]) ##1 (maint_active || !$past(maint_remote)))
    else $error("remote request not stored or not active");

  a_trip_decode: assert property (@(posedge clk) disable iff (!rstn)
    trip_code == 3'h3 |=> cfg.trip_tenths == MULT_3)
    else $error("trip code 3 not 6 times");

  a_trip_cap: assert property (@(posedge clk) disable iff (!rstn)
    capped |=> cfg.trip_tenths <= MULT_4)
    else $error("capped frame above 8 times");

  a_sign_range: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && req.write && req.index == IDX_SIGN && req.wdata > SIGN_MAX
      |=> rsp.error && $stable(sign_code))
    else $error("illegal sign code accepted");

  a_interval_range: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && req.write && req.index == IDX_INTERVAL && req.wdata < INTERVAL_MIN
      |=> rsp.error ##1 cfg.demand_minutes == $past(interval, 2))
    else $error("short interval accepted");

  a_life_range: assert property (@(posedge clk) disable iff (!rstn)
    life_level >= LIFE_MIN[6:0] && life_level <= LIFE_MAX[6:0])
    else $error("life level out of range");

  a_life_invert: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cfg.life_threshold == LIFE_FULL - $past(life_level))
    else $error("life threshold not inverted");

  a_variant_gate: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && !volt_variant && req.index == IDX_DIRECTION |=> rsp.valid && rsp.error)
    else $error("variant-only index served");

  a_trip_low: assert property (@(posedge clk) disable iff (!rstn)
    trip_code == 3'h1 |=> cfg.trip_tenths == MULT_1)
    else $error("trip code 1 not lowest multiple");

  a_trip_full: assert property (@(posedge clk) disable iff (!rstn)
    trip_code == 3'h5 && !capped |=> cfg.trip_tenths == MULT_5)
    else $error("trip code 5 not 10 times on open frame");

  a_trip_refuse: assert property (@(posedge clk) disable iff (!rstn)
    req.valid && req.write && req.index == IDX_TRIP &&
      (req.wdata > TRIP_MAX || (capped && req.wdata == TRIP_MAX))
      |=> rsp.error && $stable(trip_code))
    else $error("illegal trip code accepted");

  a_variant_dir: assert property (@(posedge clk) disable iff (!rstn)
    !volt_variant |=> !cfg.supply_reverse)
    else $error("reverse supply shown without metering variant");

  a_sign_decode: assert property (@(posedge clk) disable iff (!rstn)
    sign_code == 2'h2 |=> cfg.sign_conv == TUS_SIGN_IEEE_OLD)
    else $error("sign code 2 not older convention");

  a_window_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cfg.demand_sliding == $past(window))
    else $error("demand window not applied");

  a_interval_apply: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cfg.demand_minutes == $past(interval))
    else $error("demand interval not applied");

  a_phase_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cfg.phase_clockwise == $past(phase))
    else $error("phase sequence not applied");

  a_alarm_compare: assert property (@(posedge clk) disable iff (!rstn)
    ##1 life_alarm == ($past(life_remaining) <= $past(cfg.life_threshold)))
    else $error("life alarm not against threshold");

  a_error_quiet: assert property (@(posedge clk) disable iff (!rstn)
    rsp.valid && rsp.error |-> rsp.rdata == 16'h0000)
    else $error("refused access returned data");

  a_answer_timing: assert property (@(posedge clk) disable iff (!rstn)
    ##1 rsp.valid == $past(req.valid))
    else $error("answer not one cycle after request");

  c_remote_on: cover property (@(posedge clk) disable iff (!rstn)
    accept && req.index == IDX_MAINT && req.wdata[0] ##2 maint_active);

  c_trip_capped: cover property (@(posedge clk) disable iff (!rstn)
    capped && trip_code == 3'h5);

  c_life_alarm: cover property (@(posedge clk) disable iff (!rstn) $rose(life_alarm));

  c_refused: cover property (@(posedge clk) disable iff (!rstn) rsp.valid && rsp.error);

  c_variant_refused: cover property (@(posedge clk) disable iff (!rstn) rsp.error && !volt_variant);

endmodule // tus_setpoints

// ### dv/tus_ctrl_model.sv
`timescale 1ns/100ps
module tus_ctrl_model
  import tus_pkg::*;
(
  input  logic     clk,
  output tus_req_s req
);

  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus until the first request
  initial begin
    req = '0;
  end

  // One request per call, launched just after an edge and held for the taking edge
  task automatic issue(input logic wr, input logic [7:0] idx, input logic [15:0] data);
    @(posedge clk);
    #1;
    req.valid = 1'b1;
    req.write = wr;
    req.index = idx;
    req.wdata = data; // Range kept by caller except in refusal runs
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    // Released fields go inverted so stale values are never trusted
    req.write = ~wr;
    req.index = ~idx;
    req.wdata = ~data;
  endtask
endmodule // tus_ctrl_model

// ### dv/tb_trip_unit_system_setpoints.sv
`timescale 1ns/100ps
module tb_trip_unit_system_setpoints
  import tus_pkg::*;
;
  logic        clk;
  logic        rstn;
  tus_req_s    req;
  logic        maint_switch;
  logic        maint_terminal;
  logic        volt_variant;
  logic [2:0]  frame_size;
  logic [12:0] rated_amps;
  logic [6:0]  life_remaining;
  tus_rsp_s    rsp;
  tus_cfg_s    cfg;
  logic        maint_active;
  logic        life_alarm;
  logic [15:0] relay_one;
  logic [15:0] relay_two;
  int          error_cnt;
  int          checks;
  logic [17:0] exp_q[$];
  logic [31:0] rnd;
  logic [15:0] v;
  logic [15:0] vi;

  tus_ctrl_model u_ctrl (.clk(clk), .req(req));

  tus_setpoints u_dut (
    .clk(clk), .rstn(rstn), .req(req), .maint_switch(maint_switch),
    .maint_terminal(maint_terminal), .volt_variant(volt_variant), .frame_size(frame_size),
    .rated_amps(rated_amps), .life_remaining(life_remaining), .rsp(rsp), .cfg(cfg),
    .maint_active(maint_active), .life_alarm(life_alarm), .relay_one(relay_one), .relay_two(relay_two)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Compare and count
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Note expected answer, then let the controller model issue it
  task automatic acc(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     input logic err, input logic [15:0] rd);
    exp_q.push_back({~w, err, rd});
    u_ctrl.issue(w, idx, d);
  endtask

  // Let cfg and synchronised pins settle; pins need three edges
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Response watcher: settled mid-cycle, one note per answer
  always @(negedge clk) begin
    logic [17:0] e;
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected rsp", 18'h00001, 18'h00000);
      end else begin
        e = exp_q.pop_front();
        check("rsp.error", 18'(rsp.error), 18'(e[16]));
        if (e[17]) check("rsp.rdata", 18'(rsp.rdata), 18'(e[15:0]));
      end
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    #(20 * 20000);
    error_cnt++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    rnd = 32'h1d15ed1c;
    rstn = 1'b0;
    maint_switch = 1'b0;
    maint_terminal = 1'b0;
    volt_variant = 1'b1;
    frame_size = 3'h0;
    rated_amps = 13'h0064;
    life_remaining = 7'h32;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    // Reset values read back
    acc(1'b0, IDX_TRIP, 16'h0000, 1'b0, 16'h0001);
    acc(1'b0, IDX_INTERVAL, 16'h0000, 1'b0, 16'h000f);
    acc(1'b0, IDX_LIFE, 16'h0000, 1'b0, 16'h004b);
    acc(1'b0, IDX_RELAY_ONE, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, 8'h0a, 16'h0000, 1'b1, 16'h0000);
    settle();
    check("life_threshold", 18'(cfg.life_threshold), 18'h00019);
    // Trip codes, both refused edges
    for (int c = 1; c <= 5; c++) begin
      acc(1'b1, IDX_TRIP, 16'(c), 1'b0, 16'h0000);
      settle();
      check("trip_tenths", 18'(cfg.trip_tenths),
            18'(c == 1 ? MULT_1 : c == 2 ? MULT_2 : c == 3 ? MULT_3 : c == 4 ? MULT_4 : MULT_5));
    end
    acc(1'b1, IDX_TRIP, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, IDX_TRIP, 16'h0006, 1'b1, 16'h0000);
    acc(1'b0, IDX_TRIP, 16'h0000, 1'b0, 16'h0005);
    // Capped frame at both ratings: code 5 clamps and is refused
    for (int k = 0; k < 2; k++) begin
      frame_size = FRAME_CAPPED;
      rated_amps = k ? RATING_B : RATING_A;
      settle();
      check("trip_capped", 18'(cfg.trip_tenths), 18'(MULT_4));
      acc(1'b1, IDX_TRIP, 16'h0005, 1'b1, 16'h0000);
      acc(1'b1, IDX_TRIP, 16'h0004, 1'b0, 16'h0000);
      acc(1'b1, IDX_TRIP, 16'h0005, 1'b1, 16'h0000);
      frame_size = 3'h0;
      acc(1'b1, IDX_TRIP, 16'h0005, 1'b0, 16'h0000);
    end
    // Sign conventions
    for (int c = 0; c <= 2; c++) begin
      acc(1'b1, IDX_SIGN, 16'(c), 1'b0, 16'h0000);
      settle();
      check("sign_conv", 18'(cfg.sign_conv), 18'(c));
    end
    acc(1'b1, IDX_SIGN, 16'h0003, 1'b1, 16'h0000);
    // One-bit settings, back to back, then refused value 2
    acc(1'b1, IDX_DIRECTION, 16'h0001, 1'b0, 16'h0000);
    acc(1'b1, IDX_WINDOW, 16'h0001, 1'b0, 16'h0000);
    acc(1'b1, IDX_PHASE, 16'h0001, 1'b0, 16'h0000);
    acc(1'b1, IDX_PHASE, 16'h0002, 1'b1, 16'h0000);
    settle();
    check("bits", 18'({cfg.supply_reverse, cfg.demand_sliding, cfg.phase_clockwise}), 18'h00007);
    acc(1'b1, IDX_WINDOW, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, IDX_PHASE, 16'h0000, 1'b0, 16'h0000);
    settle();
    check("bits_off", 18'({cfg.demand_sliding, cfg.phase_clockwise}), 18'h00000);
    // Interval and alarm level: edges, then random in range
    acc(1'b1, IDX_INTERVAL, 16'h0004, 1'b1, 16'h0000);
    acc(1'b1, IDX_INTERVAL, 16'h003d, 1'b1, 16'h0000);
    acc(1'b1, IDX_LIFE, 16'h0031, 1'b1, 16'h0000);
    acc(1'b1, IDX_LIFE, 16'h0065, 1'b1, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      rnd = xorshift(rnd);
      vi = (k == 0) ? 16'h0005 : (k == 1) ? 16'h003c : 16'(5 + rnd % 56);
      acc(1'b1, IDX_INTERVAL, vi, 1'b0, 16'h0000);
      v = (k == 0) ? 16'h0032 : (k == 1) ? 16'h0064 : 16'(50 + rnd % 51);
      acc(1'b1, IDX_LIFE, v, 1'b0, 16'h0000);
      settle();
      check("life_threshold", 18'(cfg.life_threshold), 18'(7'h64 - v[6:0]));
      check("demand_minutes", 18'(cfg.demand_minutes), 18'(vi));
      life_remaining = 7'(100 - v);
      settle();
      check("life_alarm_at", 18'(life_alarm), 18'h00001);
      life_remaining = 7'(101 - v);
      settle();
      check("life_alarm_above", 18'(life_alarm), 18'h00000);
    end
    // Maintenance word: upper byte ignored, remote bit, pins
    acc(1'b1, IDX_MAINT, 16'hff00, 1'b0, 16'h0000);
    settle();
    acc(1'b0, IDX_MAINT, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, IDX_MAINT, 16'hffff, 1'b0, 16'h0000);
    settle();
    acc(1'b0, IDX_MAINT, 16'h0000, 1'b0, 16'h0101);
    acc(1'b1, IDX_MAINT, 16'h0000, 1'b0, 16'h0000);
    maint_switch = 1'b1;
    settle();
    acc(1'b0, IDX_MAINT, 16'h0000, 1'b0, 16'h0100);
    maint_switch = 1'b0;
    maint_terminal = 1'b1;
    settle();
    check("maint_terminal", 18'(maint_active), 18'h00001);
    maint_terminal = 1'b0;
    settle();
    check("maint_off", 18'(maint_active), 18'h00000);
    // Without the metering variant: refused, direction forced forward
    volt_variant = 1'b0;
    acc(1'b0, IDX_TRIP, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, IDX_LIFE, 16'h0040, 1'b1, 16'h0000);
    acc(1'b1, IDX_DIRECTION, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, IDX_RELAY_ONE, 16'hc3a5, 1'b0, 16'h0000);
    acc(1'b1, IDX_RELAY_TWO, 16'h5a3c, 1'b0, 16'h0000);
    acc(1'b0, IDX_RELAY_TWO, 16'h0000, 1'b0, 16'h5a3c);
    settle();
    check("supply_reverse", 18'(cfg.supply_reverse), 18'h00000);
    check("relay_two", 18'(relay_two), 18'h05a3c);
    check("relay_one", 18'(relay_one), 18'h0c3a5);
    check("queue_empty", 18'(exp_q.size()), 18'h00000);
    final_report();
  end
endmodule // tb_trip_unit_system_setpoints
